/* rtl/ldip_poller.sv */
// How it works
// - Eight pins times eight settings: 64 inputs.
// - Select steps through the programmed setting count.
// - Each selected timer trigger received while idle starts one sequence.
// - Fast oscillator is requested while sequence runs.
// - Wait programmed settle time after each select.
// - Each sampled group stored in monitor 0-7.
// - References come from low, mid, high registers.
// - Mismatch sets event flag and wake factor.
// - Mismatch raises port-mismatch interrupt in any mode.
// - Done interrupt after all configured ports checked.
// - Sensor power output driven during polling.
// - Sampler drives the multiplexer select outputs.
// - Timer clock source field at bits 2:0.
// - Four 4-bit prescale fields in prescaler register.
// - 8-bit divider makes clock three.
// - Mode field bits 4:0; interval mode triggers.
// - Start source bits 10:8; zero is software.
// - Master bit 11, clock selects 13:12, 15:14.
// - Update timing field at bits 7:6.
// - Input edge field at bits 1:0.
// - Per-channel simultaneous rewrite enable, mode, trigger.
// - Per-channel output enable, kind, mode, level.
// - Status bit reads 1 while sequence runs.
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`include "ldip_regs.svh"

module ldip_poller
  import ldip_pkg::*;
#(
  parameter int SETTLE_DIV = `LDIP_SETTLE_DIV
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Sensor side
  input  wire logic [7:0]  digital_input_pin_i,
  output logic      [2:0]  mux_select_out_o,
  output logic             sensor_power_out_o,
  // Other trigger sources, selections one to seven
  input  wire logic [6:0]  timer_trig_i,
  // System side
  output logic             digital_wake_factor_o,
  output logic             port_mismatch_irq_o,
  output logic             check_done_irq_o,
  output logic             osc_restart_o,
  output logic             timer_out_o
);

  localparam int NCFG = `LDIP_NCFG;
  localparam logic [31:0] CFG_MASK [NCFG] = '{
    32'h0000_00fd, 32'h0000_00ff, 32'h00ff_ffff, 32'hffff_ffff,
    32'h00ff_ffff, 32'h00ff_ffff, 32'hffff_ffff, 32'h00ff_ffff,
    32'h0000_0007, 32'h0000_ffff, 32'h0000_00ff, 32'h0000_ffdf,
    32'h0000_0003, 32'h0000_000f, 32'h0000_000f, 32'h0000_000f,
    32'h0000_000f, 32'h0000_000f, 32'h0000_000f, 32'h0000_ffff,
    32'h0000_000f
  };

  function automatic logic [31:0] ldip_bmask(input logic [3:0] s);
    ldip_bmask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : ldip_bmask

  function automatic ldip_group_t ldip_grp(input logic [63:0] v, input logic [2:0] i);
    ldip_grp = v[{i, 3'b000} +: 8];
  endfunction : ldip_grp

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  logic        req;
  logic        wr;
  logic [5:0]  widx;
  logic [31:0] bm;
  logic        in_cfg;
  logic        in_mon;
  logic        wr_evf;
  logic        wr_rdt;
  logic [31:0] rd_d;
  logic [31:0] cfg_q [NCFG];
  ldip_group_t mon_q [8];

  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr     = req && wb_we_i;
  assign widx   = wb_adr_i[7:2];
  assign bm     = ldip_bmask(wb_sel_i);
  assign in_cfg = wb_adr_i < `LDIP_A_EVENT_FLAG && wb_adr_i[1:0] == 2'b00;
  assign in_mon = wb_adr_i >= `LDIP_A_INPUT_MONITOR0 && wb_adr_i <= `LDIP_A_LAST &&
                  wb_adr_i[1:0] == 2'b00;
  assign wr_evf = wr && wb_adr_i == `LDIP_A_EVENT_FLAG && wb_sel_i[0] && wb_dat_i[0];
  assign wr_rdt = wr && wb_adr_i == `LDIP_A_TIMER_RW_TRIGGER && wb_sel_i[0] && wb_dat_i[0];

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  genvar gi;
  for (gi = 0; gi < NCFG; gi++) begin : g_cfg
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cfg_q[gi] <= (gi == 1) ? `LDIP_RST_SETTLE : `LDIP_RST_ZERO;
      end else if (wr && in_cfg && widx == 6'(gi)) begin
        cfg_q[gi] <= (cfg_q[gi] & ~(bm & CFG_MASK[gi])) |
                     (wb_dat_i & bm & CFG_MASK[gi]);
      end
    end
  end

  logic [31:0] sctl;
  logic [7:0]  settle_val;
  logic [63:0] ref_all;
  logic [63:0] en_all;
  logic [15:0] tmode;
  logic [2:0]  num;
  logic [2:0]  tsel;
  logic        poll_en;

  assign sctl       = cfg_q[0];
  assign settle_val = cfg_q[1][7:0];
  assign ref_all    = {cfg_q[4][23:0], cfg_q[3], cfg_q[2][7:0]};
  assign en_all     = {cfg_q[7][23:0], cfg_q[6], cfg_q[5][7:0]};
  assign tmode      = cfg_q[11][15:0];
  assign num        = sctl[`LDIP_NUM_MSB:`LDIP_NUM_LSB];
  assign tsel       = {sctl[`LDIP_TSEL_HI_BIT], sctl[`LDIP_TSEL_MSB:`LDIP_TSEL_LSB]};
  assign poll_en    = sctl[`LDIP_POLL_EN_BIT];

  // --------------------------------------------------------------------
  // Interval timer channel zero
  // --------------------------------------------------------------------
  logic        trun;
  logic        ttick;
  logic        rw_pend_q;
  logic [15:0] period_q;

  assign trun = cfg_q[20][0] &&
                tmode[`LDIP_STS_MSB:`LDIP_STS_LSB] == `LDIP_STS_SOFTWARE &&
                tmode[`LDIP_MD_MSB:0] == `LDIP_MD_INTERVAL;

  // With rewrite enabled, a new period waits for the trigger and the
  // period end (or only the trigger in immediate mode), so the running
  // interval is never cut short by a half-written value.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rw_pend_q <= 1'b0;
      period_q  <= 16'h0000;
    end else if (!cfg_q[13][0]) begin
      rw_pend_q <= 1'b0;
      period_q  <= cfg_q[19][15:0];
    end else if ((rw_pend_q || wr_rdt) && (cfg_q[14][0] || ttick || !trun)) begin
      rw_pend_q <= 1'b0;
      period_q  <= cfg_q[19][15:0];
    end else if (wr_rdt) begin
      rw_pend_q <= 1'b1;
    end
  end

  ldip_timer u_timer (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .prescale_i (cfg_q[9][15:0]),
    .divider_i  (cfg_q[10][7:0]),
    .mode_i     (tmode),
    .period_i   (period_q),
    .run_i      (trun),
    .out_en_i   (cfg_q[15][0]),
    .out_lvl_i  (cfg_q[18][0]),
    .tick_o     (ttick),
    .out_o      (timer_out_o)
  );

  // --------------------------------------------------------------------
  // Input synchroniser
  // --------------------------------------------------------------------
  ldip_group_t pin_m_q;
  ldip_group_t pin_s_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_m_q <= 8'h00;
      pin_s_q <= 8'h00;
    end else begin
      pin_m_q <= digital_input_pin_i;
      pin_s_q <= pin_m_q;
    end
  end

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  ldip_state_t st_q;
  logic [12:0] cnt_q;
  logic [12:0] settle_cyc;
  logic [7:0]  trig_src;
  logic        trig;
  logic        start;
  logic        last;
  logic        mismatch;
  logic        evf_q;

  assign trig_src   = {timer_trig_i, ttick};
  assign trig       = trig_src[tsel];
  assign start      = st_q == LDIP_IDLE && trig && poll_en;
  assign last       = mux_select_out_o == num;
  assign settle_cyc = (settle_val == 8'h00) ? 13'(SETTLE_DIV) :
                      13'(settle_val * SETTLE_DIV);
  assign mismatch   = |((pin_s_q ^ ldip_grp(ref_all, mux_select_out_o)) &
                        ldip_grp(en_all, mux_select_out_o));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q               <= LDIP_IDLE;
      cnt_q              <= 13'h0000;
      mux_select_out_o   <= 3'h0;
      sensor_power_out_o <= 1'b0;
      osc_restart_o      <= 1'b0;
    end else begin
      case (st_q)
        LDIP_IDLE: begin
          if (start) begin
            st_q               <= LDIP_SETTLE;
            cnt_q              <= settle_cyc;
            mux_select_out_o   <= 3'h0;
            sensor_power_out_o <= 1'b1;
            osc_restart_o      <= 1'b1;
          end
        end
        LDIP_SETTLE: begin
          cnt_q <= cnt_q - 13'h0001;
          if (cnt_q == 13'h0001) begin
            st_q <= LDIP_CHECK;
          end
        end
        LDIP_CHECK: begin
          if (last) begin
            st_q <= LDIP_FINISH;
          end else begin
            st_q             <= LDIP_SETTLE;
            cnt_q            <= settle_cyc;
            mux_select_out_o <= mux_select_out_o + 3'h1;
          end
        end
        LDIP_FINISH: begin
          st_q               <= LDIP_IDLE;
          sensor_power_out_o <= 1'b0;
          osc_restart_o      <= 1'b0;
        end
        default: begin
          st_q <= LDIP_IDLE;
        end
      endcase
    end
  end

  // Eight groups of eight pins cover all 64 inputs.
  genvar gm;
  for (gm = 0; gm < 8; gm++) begin : g_mon
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mon_q[gm] <= 8'h00;
      end else if (st_q == LDIP_CHECK && mux_select_out_o == 3'(gm)) begin
        mon_q[gm] <= pin_s_q;
      end
    end
  end

  // --------------------------------------------------------------------
  // Events and pulses
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evf_q                 <= 1'b0;
      digital_wake_factor_o <= 1'b0;
      port_mismatch_irq_o   <= 1'b0;
      check_done_irq_o      <= 1'b0;
    end else begin
      if (st_q == LDIP_CHECK && mismatch) begin
        evf_q                 <= 1'b1;
        digital_wake_factor_o <= 1'b1;
      end else if (wr_evf) begin
        evf_q                 <= 1'b0;
        digital_wake_factor_o <= 1'b0;
      end
      port_mismatch_irq_o <= st_q == LDIP_CHECK && mismatch;
      check_done_irq_o    <= st_q == LDIP_CHECK && last;
    end
  end

  // --------------------------------------------------------------------
  // Read mux and acknowledge
  // --------------------------------------------------------------------
  always_comb begin
    rd_d = 32'h0000_0000;
    if (in_cfg) begin
      rd_d = cfg_q[widx[4:0]];
    end else if (wb_adr_i == `LDIP_A_EVENT_FLAG) begin
      rd_d = {31'h0000_0000, evf_q};
    end else if (wb_adr_i == `LDIP_A_STATUS) begin
      rd_d = {31'h0000_0000, st_q != LDIP_IDLE};
    end else if (in_mon) begin
      rd_d = {24'h00_0000, mon_q[widx[2:0]]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_d : 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_seq_open;
    st_q == LDIP_SETTLE && sensor_power_out_o && mux_select_out_o == 3'h0;
  endsequence

  sequence s_seq_close;
    st_q == LDIP_FINISH ##1 (st_q == LDIP_IDLE && !sensor_power_out_o && !osc_restart_o);
  endsequence

  a_trig_start: assert property (start |=> s_seq_open and osc_restart_o)
    else $error("sequence did not open on trigger");
  a_trig_ignored: assert property (st_q == LDIP_SETTLE && trig && cnt_q > 13'h0001
    |=> st_q == LDIP_SETTLE && $stable(mux_select_out_o))
    else $error("trigger disturbed a running sequence");
  a_settle_wait: assert property (st_q == LDIP_CHECK
    |-> $past(st_q) == LDIP_SETTLE && $past(cnt_q) == 13'h0001)
    else $error("sampling before settle count elapsed");
  a_capture_store: assert property (st_q == LDIP_CHECK
    |=> mon_q[$past(mux_select_out_o)] == $past(pin_s_q))
    else $error("monitor register missed captured group");
  a_mismatch_flag: assert property (st_q == LDIP_CHECK && mismatch
    |=> (evf_q && digital_wake_factor_o && port_mismatch_irq_o) ##1 !port_mismatch_irq_o)
    else $error("mismatch not flagged");
  a_match_quiet: assert property (st_q == LDIP_CHECK && !mismatch
    |=> !port_mismatch_irq_o)
    else $error("interrupt raised on matching group");
  a_mux_step: assert property (st_q == LDIP_CHECK && !last
    |=> mux_select_out_o == $past(mux_select_out_o) + 3'h1)
    else $error("select did not advance by one");
  a_done_irq: assert property (st_q == LDIP_CHECK && last
    |=> check_done_irq_o ##0 s_seq_close)
    else $error("done interrupt or close missing");
  a_osc_running: assert property (st_q != LDIP_IDLE |-> osc_restart_o && sensor_power_out_o)
    else $error("oscillator request dropped while running");
  a_bus_ack: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge not one cycle");

endmodule : ldip_poller

/* include/ldip_regs.svh */
`ifndef LDIP_REGS_SVH
`define LDIP_REGS_SVH

// ----------------------------------------------------------------------
// Byte addresses
// ----------------------------------------------------------------------
`define LDIP_A_SEQUENCER_CONTROL 8'h00
`define LDIP_A_SETTLE_COUNT      8'h04
`define LDIP_A_REFERENCE_LOW     8'h08
`define LDIP_A_REFERENCE_MID     8'h0c
`define LDIP_A_REFERENCE_HIGH    8'h10
`define LDIP_A_COMPARE_EN_LOW    8'h14
`define LDIP_A_COMPARE_EN_MID    8'h18
`define LDIP_A_COMPARE_EN_HIGH   8'h1c
`define LDIP_A_TIMER_CLK_SRC     8'h20
`define LDIP_A_TIMER_PRESCALER   8'h24
`define LDIP_A_TIMER_CLK3_DIV    8'h28
`define LDIP_A_TIMER_CH_MODE     8'h2c
`define LDIP_A_TIMER_EDGE_MODE   8'h30
`define LDIP_A_TIMER_RW_ENABLE   8'h34
`define LDIP_A_TIMER_RW_TRIG_MD  8'h38
`define LDIP_A_TIMER_OUT_ENABLE  8'h3c
`define LDIP_A_TIMER_OUT_KIND    8'h40
`define LDIP_A_TIMER_OUT_CONFIG  8'h44
`define LDIP_A_TIMER_OUT_LOGIC   8'h48
`define LDIP_A_TIMER_CH_DATA     8'h4c
`define LDIP_A_TIMER_START       8'h50
`define LDIP_A_EVENT_FLAG        8'h54
`define LDIP_A_TIMER_RW_TRIGGER  8'h58
`define LDIP_A_STATUS            8'h5c
`define LDIP_A_INPUT_MONITOR0    8'h60
`define LDIP_A_LAST              8'h7c
`define LDIP_NCFG                21

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LDIP_POLL_EN_BIT   0
`define LDIP_NUM_MSB       6
`define LDIP_NUM_LSB       4
`define LDIP_TSEL_HI_BIT   7
`define LDIP_TSEL_MSB      3
`define LDIP_TSEL_LSB      2
`define LDIP_MD_MSB        4
`define LDIP_STS_MSB       10
`define LDIP_STS_LSB       8
`define LDIP_CCS_MSB       13
`define LDIP_CCS_LSB       12
`define LDIP_MD_INTERVAL   5'h00
`define LDIP_STS_SOFTWARE  3'h0

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define LDIP_RST_ZERO      32'h0000_0000
`define LDIP_RST_SETTLE    32'h0000_0001
`define LDIP_SETTLE_DIV    20

`endif

/* include/ldip_pkg.sv */
package ldip_pkg;

  typedef enum logic [3:0] {
    LDIP_IDLE   = 4'b0001,
    LDIP_SETTLE = 4'b0010,
    LDIP_CHECK  = 4'b0100,
    LDIP_FINISH = 4'b1000
  } ldip_state_t;

  typedef logic [7:0] ldip_group_t;

endpackage : ldip_pkg

/* rtl/ldip_timer.sv */
`include "ldip_regs.svh"

module ldip_timer
  import ldip_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Configuration
  input  wire logic [15:0] prescale_i,
  input  wire logic [7:0]  divider_i,
  input  wire logic [15:0] mode_i,
  input  wire logic [15:0] period_i,
  input  wire logic        run_i,
  input  wire logic        out_en_i,
  input  wire logic        out_lvl_i,
  // Results
  output logic             tick_o,
  output logic             out_o
);

  function automatic logic [15:0] ldip_pmask(input logic [3:0] p);
    ldip_pmask = (16'h0001 << p) - 16'h0001;
  endfunction : ldip_pmask

  logic [15:0] pre_q;
  logic [7:0]  div_q;
  logic [15:0] cnt_q;
  logic [3:0]  ck;
  logic [3:0]  cks;
  logic        ck3;
  logic        cclk;

  // --------------------------------------------------------------------
  // Prescaled clocks zero to three
  // --------------------------------------------------------------------
  genvar g;
  for (g = 0; g < 4; g++) begin : g_ck
    assign ck[g] = (pre_q & ldip_pmask(prescale_i[g*4 +: 4])) ==
                   ldip_pmask(prescale_i[g*4 +: 4]);
  end
  assign ck3  = ck[3] && (div_q == divider_i);
  assign cks  = {ck3, ck[2:0]};
  assign cclk = cks[mode_i[`LDIP_CCS_MSB:`LDIP_CCS_LSB]];

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      pre_q <= 16'h0000;
      div_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 16'h0001;
      if (ck[3]) begin
        div_q <= (div_q == divider_i) ? 8'h00 : div_q + 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------
  // Interval counter
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_q  <= period_i;
      tick_o <= 1'b0;
    end else if (cclk && cnt_q == 16'h0000) begin
      cnt_q  <= period_i;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cclk ? cnt_q - 16'h0001 : cnt_q;
      tick_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !out_en_i) begin
      out_o <= rst_i ? 1'b0 : out_lvl_i;
    end else if (tick_o) begin
      out_o <= ~out_o;
    end
  end

endmodule : ldip_timer

/* test/ldip_sensor_model.sv */
module ldip_sensor_model (
  // Clock
  input  wire logic        clk_i,
  // Sampler side
  input  wire logic [2:0]  mux_select_out_i,
  input  wire logic        sensor_power_out_i,
  input  wire logic [63:0] pattern_i,
  output logic      [7:0]  pins_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] noise_q = 8'h5a;

  // Unpowered sensors give no valid level, so the pins wander every cycle.
  always_ff @(posedge clk_i) begin
    noise_q <= ~noise_q + 8'h01;
  end

  assign pins_o = sensor_power_out_i ? pattern_i[{mux_select_out_i, 3'b000} +: 8] : noise_q;
endmodule : ldip_sensor_model

/* test/tb_low_power_digital_input_poller.sv */
`include "ldip_regs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end

module tb_low_power_digital_input_poller;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        cyc = 0;
  logic        stb = 0;
  logic        we = 0;
  logic [7:0]  adr = 0;
  logic [31:0] wdat = 0;
  logic [3:0]  sel = 0;
  logic [3:0]  wsel = 4'hf;
  logic [31:0] rdat;
  logic [6:0]  trig = 0;
  logic [63:0] pattern = 0;
  logic [7:0]  pins;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, sensor_power_out_o, digital_wake_factor_o, port_mismatch_irq_o;
  logic        check_done_irq_o, osc_restart_o;
  logic        timer_out_o, tout_q;
  logic [2:0]  mux_select_out_o;
  int          miscompares = 0;
  int          check_count = 0;
  int          mism_cnt, done_cnt, mux_max;
  int          pwr_cnt, tog_cnt;
  localparam int SETTLE = 6;
  int          seed = 32'h1bc3e21e;
  logic [7:0]  tadr [11] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c,
                             8'h40, 8'h44, 8'h48};
  logic [31:0] tmsk [11] = '{32'h7, 32'hffff, 32'hff, 32'hffdf, 32'h3, 32'hf, 32'hf, 32'hf,
                             32'hf, 32'hf, 32'hf};

  ldip_poller #(.SETTLE_DIV(1)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .digital_input_pin_i(pins), .mux_select_out_o(mux_select_out_o),
    .sensor_power_out_o(sensor_power_out_o), .timer_trig_i(trig),
    .digital_wake_factor_o(digital_wake_factor_o), .port_mismatch_irq_o(port_mismatch_irq_o),
    .check_done_irq_o(check_done_irq_o), .osc_restart_o(osc_restart_o),
    .timer_out_o(timer_out_o));

  ldip_sensor_model sensors (
    .clk_i(clk_i), .mux_select_out_i(mux_select_out_o),
    .sensor_power_out_i(sensor_power_out_o), .pattern_i(pattern), .pins_o(pins));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    mism_cnt += int'(port_mismatch_irq_o === 1'b1);
    done_cnt += int'(check_done_irq_o === 1'b1);
    pwr_cnt  += int'(sensor_power_out_o === 1'b1);
    tog_cnt  += int'(timer_out_o !== tout_q);
    tout_q   = timer_out_o;
    if (sensor_power_out_o === 1'b1 && int'(mux_select_out_o) > mux_max) begin
      mux_max = mux_select_out_o;
    end
  end

  // ----------------------------------------------------------------------
  // Bus, trigger and closing tasks
  // ----------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1;
    stb  <= 1;
    we   <= w;
    adr  <= a;
    sel  <= wsel;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      $display("BAD %0t bus acknowledge timed out", $time);
      end_sim();
    end
    rdat = wb_dat_o;
    cyc <= 0; stb <= 0; we <= 0;
  endtask : wb

  task automatic pulse();
    @(posedge clk_i);
    trig <= 7'h01;
    @(posedge clk_i);
    trig <= 7'h00;
  endtask : pulse

  task automatic wait_done(input int cnt);
    int n;
    for (n = 0; n < 800 && done_cnt < cnt; n++) @(posedge clk_i);
    if (n >= 800) begin
      miscompares++;
      $display("BAD %0t sequence end timed out", $time);
      end_sim();
    end
  endtask : wait_done

  // ----------------------------------------------------------------------
  // One polling sequence against the queue-free reference model
  // ----------------------------------------------------------------------
  task automatic run(input int num, input logic [63:0] pat, flip, en);
    logic [63:0] refv, diff;
    int          exp_m;
    refv = pat ^ flip;
    diff = flip & en;
    pattern <= pat;
    wb(1, 8'h08, {24'h0, refv[7:0]});
    wb(1, 8'h0c, refv[39:8]);
    wb(1, 8'h10, {8'h0, refv[63:40]});
    wb(1, 8'h14, {24'h0, en[7:0]});
    wb(1, 8'h18, en[39:8]);
    wb(1, 8'h1c, {8'h0, en[63:40]});
    wb(1, 8'h00, 32'h5 | (num << 4));
    mism_cnt = 0;
    done_cnt = 0;
    mux_max = 0;
    pwr_cnt = 0;
    pulse();
    wb(0, 8'h5c, 0);
    `CHK(rdat[0], 1'b1);
    `CHK(osc_restart_o, 1'b1);
    `CHK(sensor_power_out_o, 1'b1);
    pulse();
    wait_done(1);
    repeat (20) @(posedge clk_i);
    `CHK(done_cnt, 1);
    `CHK(sensor_power_out_o, 1'b0);
    `CHK(mux_max, num);
    `CHK(pwr_cnt, (num + 1) * (SETTLE + 1) + 1);
    exp_m = 0;
    for (int g = 0; g <= num; g++) exp_m += int'(diff[8*g +: 8] != 8'h00);
    `CHK(mism_cnt, exp_m);
    for (int g = 0; g <= num; g++) begin
      wb(0, 8'h60 + 8'(4 * g), 0);
      `CHK(rdat[7:0], pat[8*g +: 8]);
    end
    wb(0, 8'h54, 0);
    `CHK(rdat[0], 1'(exp_m > 0));
    `CHK(digital_wake_factor_o, 1'(exp_m > 0));
    wb(1, 8'h54, 1);
    wb(1, 8'h00, 0);
    `CHK(digital_wake_factor_o, 1'b0);
    $display("test run num %0d done", num);
  endtask : run

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [31:0] v;
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h04, 0);
    `CHK(rdat, 32'h1);
    wb(0, 8'h80, 0);
    `CHK(rdat, 32'h0);
    wb(1, 8'h5c, 32'h1);
    wb(0, 8'h5c, 0);
    `CHK(rdat, 32'h0);
    for (int i = 0; i < 11; i++) begin
      v = $random(seed);
      wb(0, tadr[i], 0);
      `CHK(rdat, 32'h0);
      wb(1, tadr[i], v);
      wb(0, tadr[i], 0);
      `CHK(rdat, v & tmsk[i]);
      wsel = 4'h1;
      wb(1, tadr[i], ~v);
      wsel = 4'hf;
      v = {v[31:8], ~v[7:0]};
      wb(0, tadr[i], 0);
      `CHK(rdat, v & tmsk[i]);
      wb(1, tadr[i], 0);
    end
    $display("test registers done");
    wb(1, 8'h04, SETTLE);
    run(7, {$random(seed), $random(seed)}, 64'h0, 64'hffff_ffff_ffff_ffff);
    for (int r = 0; r < 6; r++)
      run($random(seed) & 7, {$random(seed), $random(seed)},
          {$random(seed), $random(seed)} & {$random(seed), $random(seed)},
          {$random(seed), $random(seed)});
    pulse();
    repeat (3) @(posedge clk_i);
    `CHK(sensor_power_out_o, 1'b0);
    wb(1, 8'h4c, 9);
    wb(1, 8'h48, 1);
    wb(1, 8'h3c, 1);
    `CHK(timer_out_o, 1'b1);
    wb(1, 8'h00, 32'h1);
    mism_cnt = 0;
    done_cnt = 0;
    tog_cnt = 0;
    wb(1, 8'h50, 1);
    wait_done(2);
    `CHK(done_cnt, 2);
    `CHK(tog_cnt, 2);
    wb(1, 8'h00, 0);
    wb(1, 8'h50, 0);
    $display("test timer done");
    end_sim();
  end
endmodule : tb_low_power_digital_input_poller
